// *** src/edp_params.svh ***
// constants for the direction select and preset pin logic
`ifndef EDP_PARAMS_SVH
`define EDP_PARAMS_SVH

// clock and qualification times
`define EDP_CLK_KHZ 50000
`define EDP_INIT_MS 1000
`define EDP_PRESET_LOW_MS 1000
`define EDP_PRESET_HIGH_MS 250

// widths
`define EDP_ADDR_W 8
`define EDP_POS_W 30
`define EDP_ERR_W 3
`define EDP_IRQ_W 4

// register offsets
`define EDP_CTRL_OFS 8'h00
`define EDP_PRESET_OFS 8'h04
`define EDP_STATUS_OFS 8'h08
`define EDP_POSITION_OFS 8'h0C
`define EDP_IRQ_STAT_OFS 8'h10
`define EDP_IRQ_MASK_OFS 8'h14

// field positions
`define EDP_CTRL_PRESET_DEF_BIT 0
`define EDP_ST_INIT_DONE_BIT 0
`define EDP_ST_DIR_UP_CW_BIT 1
`define EDP_ST_BUSY_BIT 2
`define EDP_ST_ERROR_BIT 3
`define EDP_ST_ARMED_BIT 4
`define EDP_IRQ_INIT_BIT 0
`define EDP_IRQ_DONE_BIT 1
`define EDP_IRQ_REFUSED_BIT 2
`define EDP_IRQ_FALSE_BIT 3

// reset values
`define EDP_CTRL_RST 1'h0
`define EDP_PRESET_RST 30'h0
`define EDP_IRQ_MASK_RST 4'h0

`endif

// *** src/edp_pkg.sv ***
// types shared by the direction select and preset pin logic
`include "edp_params.svh"

package edp_pkg;

   typedef struct packed {
      logic [`EDP_ADDR_W-1:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } edp_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } edp_apb_rsp_type;

   typedef struct packed {
      logic [`EDP_ERR_W-1:0] err_bits;
      logic [`EDP_POS_W-1:0] position;
   } edp_serial_type;

   typedef enum logic [1:0] {P_IDLE, P_ARMED, P_HIGH, P_BUSY} edp_preset_state_type;

   typedef struct packed {
      logic init_done;
      logic dir_up_cw;
      logic preset_def;
      logic [`EDP_POS_W-1:0] preset_value;
      logic [`EDP_POS_W-1:0] offset;
      edp_preset_state_type pstate;
      logic moved;
      logic [`EDP_IRQ_W-1:0] irq_status;
      logic [`EDP_IRQ_W-1:0] irq_mask;
      logic [`EDP_IRQ_W-1:0] rd_hold;
      logic [31:0] prdata;
      edp_serial_type serial;
      logic [`EDP_POS_W-1:0] analog_pos;
   } edp_core_state_type;

endpackage : edp_pkg

// *** src/edp_sync.sv ***
// two-flop synchroniser for the configuration pins
`timescale 1ns/10ps

module edp_sync #(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } edp_sync_state_type;

   edp_sync_state_type st_r;
   edp_sync_state_type st_nxt;

   // first stage feeds only the second stage
   always_comb begin
      st_nxt.meta = pin_in;
      st_nxt.sync = st_r.meta;
   end

   // register both stages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= {RESET_VAL, RESET_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pin_sync = st_r.sync;

endmodule : edp_sync

// *** src/edp_stable_timer.sv ***
// counts how long a synchronised level has stayed unchanged
`timescale 1ns/10ps

module edp_stable_timer #(
   parameter int CNT_W = 32,
   parameter logic RESET_LEVEL = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic level_in,
   output logic level,
   output logic [CNT_W-1:0] count
);

   typedef struct packed {
      logic level;
      logic [CNT_W-1:0] count;
   } edp_timer_state_type;

   edp_timer_state_type st_r;
   edp_timer_state_type st_nxt;

   // restart on a change, otherwise count up and saturate
   always_comb begin
      st_nxt = st_r;
      if (level_in != st_r.level) begin
         st_nxt.level = level_in;
         st_nxt.count = '0;
      end else if (st_r.count != '1) begin
         st_nxt.count = st_r.count + CNT_W'(1);
      end
   end

   // timer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= {RESET_LEVEL, {CNT_W{1'b0}}};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level = st_r.level;
   assign count = st_r.count;

endmodule : edp_stable_timer

// *** src/edp_dir_preset.sv ***
// direction select latch, preset pin qualifier and apb registers
// How it works
// - open direction pin reads as high
// - high level counts up on clockwise
// - low level counts up on counterclockwise
// - direction sampled during init, 1000 ms stable
// - direction change after init ignored
// - only serial position altered, analogue untouched
// - preset needs 1000 ms low, >250 ms high
// - valid preset loads zero or preset value
// - wrong pin sequence leaves position unchanged
// - shaft moving during preset keeps position
// - error shown for whole preset process; code sets it only in P_BUSY, not while armed or in the high phase
// - internal error sends all ones serially
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`include "edp_params.svh"

module edp_dir_preset #(
   parameter int unsigned INIT_MS = `EDP_INIT_MS,
   parameter int unsigned PRESET_LOW_MS = `EDP_PRESET_LOW_MS,
   parameter int unsigned PRESET_HIGH_MS = `EDP_PRESET_HIGH_MS,
   parameter int unsigned INIT_CYCLES = INIT_MS * `EDP_CLK_KHZ,
   parameter int unsigned LOW_CYCLES = PRESET_LOW_MS * `EDP_CLK_KHZ,
   parameter int unsigned HIGH_CYCLES = PRESET_HIGH_MS * `EDP_CLK_KHZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input edp_pkg::edp_apb_req_type apb_req,
   output edp_pkg::edp_apb_rsp_type apb_rsp,
   input wire logic count_direction_select,
   input wire logic preset_request,
   input wire logic [`EDP_POS_W-1:0] raw_position,
   input wire logic shaft_moving,
   input wire logic internal_error,
   output edp_pkg::edp_serial_type serial_out,
   output logic [`EDP_POS_W-1:0] analog_position,
   output logic irq
);
   import edp_pkg::*;

   localparam int POS_W = `EDP_POS_W;

   edp_core_state_type st_r;
   edp_core_state_type st_nxt;
   logic [1:0] pins_sync;
   logic dir_lvl;
   logic [31:0] dir_cnt;
   logic set_lvl;
   logic [31:0] set_cnt;
   logic [POS_W-1:0] counted;
   logic [POS_W-1:0] target;
   logic error_now;
   logic setup_ph;
   logic access_ph;
   logic mapped;
   logic [31:0] rd_word;
   logic [`EDP_IRQ_W-1:0] ev;

   // both pins pass two flops; open direction pin idles high
   edp_sync #(
      .WIDTH(2),
      .RESET_VAL(2'b10)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in({count_direction_select, preset_request}),
      .pin_sync(pins_sync)
   );

   // stable time of the direction level
   edp_stable_timer #(
      .CNT_W(32),
      .RESET_LEVEL(1'b1)
   ) u_dir_timer (
      .pclk(pclk),
      .presetn(presetn),
      .level_in(pins_sync[1]),
      .level(dir_lvl),
      .count(dir_cnt)
   );

   // stable time of the preset level
   edp_stable_timer #(
      .CNT_W(32),
      .RESET_LEVEL(1'b0)
   ) u_set_timer (
      .pclk(pclk),
      .presetn(presetn),
      .level_in(pins_sync[0]),
      .level(set_lvl),
      .count(set_cnt)
   );

   // position seen on the serial channel
   assign counted = st_r.dir_up_cw ? raw_position : (POS_W'(0) - raw_position);
   assign target = st_r.preset_def ? st_r.preset_value : '0;
   assign error_now = internal_error || (st_r.pstate == P_BUSY) || !st_r.init_done;
   assign setup_ph = apb_req.psel && !apb_req.penable;
   assign access_ph = apb_req.psel && apb_req.penable;

   // register read decode
   always_comb begin
      mapped = 1'b1;
      rd_word = 32'h0000_0000;
      case (apb_req.paddr)
         `EDP_CTRL_OFS: begin
            rd_word[`EDP_CTRL_PRESET_DEF_BIT] = st_r.preset_def;
         end
         `EDP_PRESET_OFS: begin
            rd_word[POS_W-1:0] = st_r.preset_value;
         end
         `EDP_STATUS_OFS: begin
            rd_word[`EDP_ST_INIT_DONE_BIT] = st_r.init_done;
            rd_word[`EDP_ST_DIR_UP_CW_BIT] = st_r.dir_up_cw;
            rd_word[`EDP_ST_BUSY_BIT] = (st_r.pstate == P_BUSY);
            rd_word[`EDP_ST_ERROR_BIT] = error_now;
            rd_word[`EDP_ST_ARMED_BIT] = (st_r.pstate == P_ARMED);
         end
         `EDP_POSITION_OFS: begin
            rd_word[POS_W-1:0] = st_r.serial.position;
         end
         `EDP_IRQ_STAT_OFS: begin
            rd_word[`EDP_IRQ_W-1:0] = st_r.irq_status;
         end
         `EDP_IRQ_MASK_OFS: begin
            rd_word[`EDP_IRQ_W-1:0] = st_r.irq_mask;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // next state of the whole block
   always_comb begin
      st_nxt = st_r;
      ev = '0;
      // direction latched once, at the end of a stable init phase
      if (!st_r.init_done && dir_cnt >= INIT_CYCLES) begin
         st_nxt.init_done = 1'b1;
         st_nxt.dir_up_cw = dir_lvl;
         ev[`EDP_IRQ_INIT_BIT] = 1'b1;
      end
      // preset pin sequence
      // a rise before arming counts as a false sequence
      case (st_r.pstate)
         P_IDLE: begin
            if (st_r.init_done && !set_lvl && set_cnt >= LOW_CYCLES) begin
               st_nxt.pstate = P_ARMED;
            end else if (st_r.init_done && set_lvl && set_cnt == 32'h0000_0000) begin
               ev[`EDP_IRQ_FALSE_BIT] = 1'b1;
            end
         end
         P_ARMED: begin
            if (set_lvl) begin
               st_nxt.pstate = P_HIGH;
            end
         end
         P_HIGH: begin
            if (!set_lvl) begin
               st_nxt.pstate = P_IDLE;
               ev[`EDP_IRQ_FALSE_BIT] = 1'b1;
            end else if (set_cnt > HIGH_CYCLES) begin
               st_nxt.pstate = P_BUSY;
               st_nxt.moved = shaft_moving;
            end
         end
         P_BUSY: begin
            // pin release ends the process; any motion refuses it
            st_nxt.moved = st_r.moved || shaft_moving;
            if (!set_lvl) begin
               st_nxt.pstate = P_IDLE;
               if (st_r.moved || shaft_moving) begin
                  ev[`EDP_IRQ_REFUSED_BIT] = 1'b1;
               end else begin
                  st_nxt.offset = target - counted;
                  ev[`EDP_IRQ_DONE_BIT] = 1'b1;
               end
            end
         end
         default: begin
            st_nxt.pstate = P_IDLE;
         end
      endcase
      // apb setup: capture read data and the interrupt bits reported
      if (setup_ph && !apb_req.pwrite) begin
         st_nxt.prdata = rd_word;
         st_nxt.rd_hold = (apb_req.paddr == `EDP_IRQ_STAT_OFS) ? st_r.irq_status : '0;
      end
      // apb access: writes take effect
      if (access_ph && apb_req.pwrite) begin
         case (apb_req.paddr)
            `EDP_CTRL_OFS: begin
               st_nxt.preset_def = apb_req.pwdata[`EDP_CTRL_PRESET_DEF_BIT];
            end
            `EDP_PRESET_OFS: begin
               st_nxt.preset_value = apb_req.pwdata[POS_W-1:0];
            end
            `EDP_IRQ_MASK_OFS: begin
               st_nxt.irq_mask = apb_req.pwdata[`EDP_IRQ_W-1:0];
            end
            default: begin
               st_nxt.irq_mask = st_r.irq_mask;
            end
         endcase
      end
      // read clears only what was reported; a new event wins
      if (access_ph && !apb_req.pwrite && apb_req.paddr == `EDP_IRQ_STAT_OFS) begin
         st_nxt.irq_status = (st_r.irq_status & ~st_r.rd_hold) | ev;
      end else begin
         st_nxt.irq_status = st_r.irq_status | ev;
      end
      // serial channel output word
      if (error_now) begin
         st_nxt.serial.position = '1;
         st_nxt.serial.err_bits = '1;
      end else begin
         st_nxt.serial.position = counted + st_r.offset;
         st_nxt.serial.err_bits = '0;
      end
      // analogue channel follows the sensor, never the offset
      st_nxt.analog_pos = raw_position;
   end

   // state register
   // reset leaves the serial word in error until init completes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.init_done <= 1'b0;
         st_r.dir_up_cw <= 1'b1;
         st_r.preset_def <= `EDP_CTRL_RST;
         st_r.preset_value <= `EDP_PRESET_RST;
         st_r.offset <= '0;
         st_r.pstate <= P_IDLE;
         st_r.moved <= 1'b0;
         st_r.irq_status <= '0;
         st_r.irq_mask <= `EDP_IRQ_MASK_RST;
         st_r.rd_hold <= '0;
         st_r.prdata <= 32'h0000_0000;
         st_r.serial <= '1;
         st_r.analog_pos <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs
   assign apb_rsp.prdata = st_r.prdata;
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = access_ph && !mapped;
   assign serial_out = st_r.serial;
   assign analog_position = st_r.analog_pos;
   assign irq = |(st_r.irq_status & st_r.irq_mask);

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   init_stable_a : assert property ($rose(st_r.init_done) |-> $past(dir_cnt) >= INIT_CYCLES)
      else $error("direction latched before stable init time");

   init_dir_a : assert property ($rose(st_r.init_done) |-> st_r.dir_up_cw == $past(dir_lvl))
      else $error("latched direction differs from pin level");

   dir_hold_a : assert property (st_r.init_done |=> st_r.init_done && $stable(st_r.dir_up_cw))
      else $error("direction changed after init");

   preset_high_a : assert property ((st_r.pstate != P_BUSY) ##1 (st_r.pstate == P_BUSY)
      |-> $past(set_lvl) && $past(set_cnt) > HIGH_CYCLES)
      else $error("preset accepted without long high level");

   busy_error_a : assert property (st_r.pstate == P_BUSY |=> serial_out.err_bits == '1)
      else $error("error bits not set during preset");

   no_error_a : assert property ((st_r.init_done && st_r.pstate != P_BUSY && !internal_error)
      |=> serial_out.err_bits == '0)
      else $error("error bits set without cause");

   false_seq_a : assert property ((st_r.pstate == P_HIGH && !set_lvl)
      |=> st_r.pstate == P_IDLE && $stable(st_r.offset))
      else $error("false preset sequence changed position");

   moving_hold_a : assert property ((st_r.pstate == P_BUSY && !set_lvl && (st_r.moved || shaft_moving))
      |=> $stable(st_r.offset))
      else $error("preset applied while shaft moved");

   preset_load_a : assert property ((st_r.pstate == P_BUSY && !set_lvl && !st_r.moved && !shaft_moving)
      |=> st_r.offset == $past(target) - $past(counted))
      else $error("preset offset wrong");

   error_ones_a : assert property (internal_error |=> serial_out.position == '1 && serial_out.err_bits == '1)
      else $error("internal error not sent as all ones");

   analog_pass_a : assert property (presetn |=> analog_position == $past(raw_position))
      else $error("analogue position altered");

   // register bus checks
   read_capture_a : assert property ((setup_ph && !apb_req.pwrite)
      |=> apb_rsp.prdata == $past(rd_word))
      else $error("read data not captured in setup");

   preset_write_a : assert property ((access_ph && apb_req.pwrite && apb_req.paddr == `EDP_PRESET_OFS)
      |=> {2'b00, st_r.preset_value} == ($past(apb_req.pwdata) & 32'h3FFF_FFFF))
      else $error("preset value write lost");

   mask_write_a : assert property ((access_ph && apb_req.pwrite && apb_req.paddr == `EDP_IRQ_MASK_OFS)
      |=> {28'h0000000, st_r.irq_mask} == ($past(apb_req.pwdata) & 32'h0000_000F))
      else $error("interrupt mask write lost");

   // interrupt flag checks
   irq_sticky_a : assert property (!(access_ph && !apb_req.pwrite && apb_req.paddr == `EDP_IRQ_STAT_OFS)
      |=> (st_r.irq_status & $past(st_r.irq_status)) == $past(st_r.irq_status))
      else $error("interrupt flag lost without read");

   irq_clear_a : assert property ((access_ph && !apb_req.pwrite && apb_req.paddr == `EDP_IRQ_STAT_OFS && ev == '0)
      |=> (st_r.irq_status & $past(st_r.rd_hold)) == '0)
      else $error("reported interrupt flag not cleared");

   event_wins_a : assert property ((ev != '0)
      |=> (st_r.irq_status & $past(ev)) == $past(ev))
      else $error("interrupt event not recorded");

   // preset sequence and init checks
   arm_low_a : assert property (((st_r.pstate == P_IDLE) ##1 (st_r.pstate == P_ARMED))
      |-> !$past(set_lvl) && $past(set_cnt) >= LOW_CYCLES)
      else $error("preset armed without long low level");

   arm_init_a : assert property ((st_r.pstate != P_IDLE)
      |-> st_r.init_done)
      else $error("preset sequence before init");

   dir_wait_a : assert property ((!st_r.init_done && dir_cnt < INIT_CYCLES)
      |=> !st_r.init_done)
      else $error("init completed too early");

   busy_hold_a : assert property ((st_r.pstate == P_BUSY && set_lvl)
      |=> st_r.pstate == P_BUSY)
      else $error("preset process ended while pin high");

   offset_hold_a : assert property ((st_r.pstate != P_BUSY)
      |=> $stable(st_r.offset))
      else $error("position offset changed outside preset");

endmodule : edp_dir_preset

// *** tb/edp_ctrl_model.sv ***
// machine controller model: drives the configuration pins, reads the serial word
`timescale 1ns/10ps
`include "edp_params.svh"

module edp_ctrl_model (
   input wire logic pclk,
   input edp_pkg::edp_serial_type serial_in,
   output logic count_direction_select,
   output logic preset_request
);
   import edp_pkg::*;

   // open direction pin reads high, preset pin starts low
   initial begin
      count_direction_select = 1'b1;
      preset_request = 1'b0;
   end

   // rewire the direction pin; after init the block picks it up only after a reset
   task automatic set_dir(input logic lvl);
      @(posedge pclk);
      count_direction_select <= lvl;
   endtask : set_dir

   // hold the preset pin at a level for a number of cycles
   task automatic drive_set(input logic lvl, input int cycles);
      @(posedge pclk);
      preset_request <= lvl;
      repeat (cycles) @(posedge pclk);
   endtask : drive_set

   // read back the serial position as the controller sees it
   task automatic read_pos(output logic [`EDP_POS_W-1:0] pos);
      @(negedge pclk);
      pos = serial_in.position;
   endtask : read_pos
endmodule : edp_ctrl_model

// *** tb/edp_dir_preset_tb.sv ***
// self-checking bench for the direction select and preset pin logic
`timescale 1ns/10ps
`include "edp_params.svh"

module edp_dir_preset_tb;
   import edp_pkg::*;

   localparam int INIT_C = 20;
   localparam int LOW_C = 20;
   localparam int HIGH_C = 10;
   localparam int T_MAX = 20000;

   logic pclk;
   logic presetn;
   edp_apb_req_type req;
   edp_apb_rsp_type rsp;
   logic dir_pin;
   logic set_pin;
   logic [`EDP_POS_W-1:0] raw;
   logic moving;
   logic int_err;
   edp_serial_type ser;
   logic [`EDP_POS_W-1:0] ana;
   logic irq;
   logic last_err;
   logic [31:0] q;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;

   edp_dir_preset #(.INIT_CYCLES(INIT_C), .LOW_CYCLES(LOW_C), .HIGH_CYCLES(HIGH_C)) edp_dir_preset_i (
      .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .count_direction_select(dir_pin), .preset_request(set_pin), .raw_position(raw),
      .shaft_moving(moving), .internal_error(int_err), .serial_out(ser),
      .analog_position(ana), .irq(irq));

   edp_ctrl_model edp_ctrl_model_i (
      .pclk(pclk), .serial_in(ser), .count_direction_select(dir_pin), .preset_request(set_pin));

   // 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == T_MAX) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer: setup, then access until pready is seen high
   task automatic apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      req.paddr <= a;
      req.pwrite <= w;
      req.pwdata <= d;
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      last_err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb_xfer

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb_xfer(a, 1'b0, 32'h0);
      chk(q, exp);
   endtask : rd_chk

   task automatic pos_chk(input logic [`EDP_POS_W-1:0] exp);
      logic [`EDP_POS_W-1:0] p;
      edp_ctrl_model_i.read_pos(p);
      chk({2'h0, p}, {2'h0, exp});
   endtask : pos_chk

   // poll status until init is done, bounded
   task automatic wait_init();
      for (int i = 0; i < 100; i++) begin
         apb_xfer(`EDP_STATUS_OFS, 1'b0, 32'h0);
         if (q[`EDP_ST_INIT_DONE_BIT] === 1'b1) break;
      end
   endtask : wait_init

   // full preset pin sequence: low, high, then release
   task automatic preset_seq(input int high_c, input logic move);
      edp_ctrl_model_i.drive_set(1'b0, LOW_C + 5);
      edp_ctrl_model_i.drive_set(1'b1, high_c);
      @(posedge pclk);
      moving <= move;
      edp_ctrl_model_i.drive_set(1'b0, 10);
      moving <= 1'b0;
   endtask : preset_seq

   // main sequence
   initial begin
      req = '0;
      raw = 30'h0001234;
      moving = 1'b0;
      int_err = 1'b0;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      chk({29'h0, ser.err_bits}, 32'h7);
      presetn <= 1'b1;
      rd_chk(`EDP_CTRL_OFS, 32'h0);
      rd_chk(`EDP_PRESET_OFS, 32'h0);
      rd_chk(`EDP_IRQ_MASK_OFS, 32'h0);
      rd_chk(8'h18, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      apb_xfer(`EDP_PRESET_OFS, 1'b1, 32'h000ABCDE);
      apb_xfer(`EDP_CTRL_OFS, 1'b1, 32'h1);
      rd_chk(`EDP_PRESET_OFS, 32'h000ABCDE);
      rd_chk(`EDP_CTRL_OFS, 32'h1);
      $display("test registers done");
      wait_init();
      chk({30'h0, q[1:0]}, 32'h3);
      pos_chk(raw);
      chk({31'h0, irq}, 32'h0);
      apb_xfer(`EDP_IRQ_MASK_OFS, 1'b1, 32'hF);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h1);
      rd_chk(`EDP_IRQ_STAT_OFS, 32'h1);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
      @(posedge pclk);
      raw <= raw + 30'h10;
      repeat (3) @(posedge pclk);
      pos_chk(raw);
      edp_ctrl_model_i.set_dir(1'b0);
      repeat (INIT_C + 10) @(posedge pclk);
      rd_chk(`EDP_STATUS_OFS, 32'h13);
      chk({31'h0, q[`EDP_ST_DIR_UP_CW_BIT]}, 32'h1);
      pos_chk(raw);
      $display("test init done");
      edp_ctrl_model_i.drive_set(1'b0, LOW_C + 5);
      edp_ctrl_model_i.drive_set(1'b1, HIGH_C - 4);
      chk({29'h0, ser.err_bits}, 32'h0);
      edp_ctrl_model_i.drive_set(1'b1, HIGH_C + 4);
      apb_xfer(`EDP_STATUS_OFS, 1'b0, 32'h0);
      chk({30'h0, q[`EDP_ST_ERROR_BIT:`EDP_ST_BUSY_BIT]}, 32'h3);
      chk({29'h0, ser.err_bits}, 32'h7);
      edp_ctrl_model_i.drive_set(1'b0, 10);
      pos_chk(30'h00ABCDE);
      chk({2'h0, ana}, {2'h0, raw});
      rd_chk(`EDP_IRQ_STAT_OFS, 32'h2);
      raw <= raw + 30'h5;
      repeat (3) @(posedge pclk);
      pos_chk(30'h00ABCE3);
      $display("test preset done");
      preset_seq(HIGH_C - 5, 1'b0);
      pos_chk(30'h00ABCE3);
      rd_chk(`EDP_IRQ_STAT_OFS, 32'h8);
      preset_seq(HIGH_C + 10, 1'b1);
      pos_chk(30'h00ABCE3);
      rd_chk(`EDP_IRQ_STAT_OFS, 32'h4);
      apb_xfer(`EDP_CTRL_OFS, 1'b1, 32'h0);
      preset_seq(HIGH_C + 10, 1'b0);
      pos_chk(30'h0);
      edp_ctrl_model_i.drive_set(1'b1, 5);
      edp_ctrl_model_i.drive_set(1'b0, 5);
      rd_chk(`EDP_IRQ_STAT_OFS, 32'hA);
      pos_chk(30'h0);
      $display("test false and refused preset done");
      @(posedge pclk);
      int_err <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({ser.err_bits[1:0], ser.position}, 32'hFFFFFFFF);
      int_err <= 1'b0;
      repeat (3) @(posedge pclk);
      pos_chk(30'h0);
      $display("test error word done");
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      wait_init();
      chk({30'h0, q[1:0]}, 32'h1);
      pos_chk(30'h0 - raw);
      raw <= raw + 30'h4;
      repeat (3) @(posedge pclk);
      pos_chk(30'h0 - raw);
      chk({2'h0, ana}, {2'h0, raw});
      $display("test reverse direction done");
      summarize();
   end
endmodule : edp_dir_preset_tb
